// [interleave_defines.svh]
// Timing counts and reset values for the interleaved converter output block
`ifndef INTERLEAVE_DEFINES_SVH
`define INTERLEAVE_DEFINES_SVH
`define CLK_PERIOD_PS 25000
`define RST_MIN_NS 200
`define RST_MIN_CYC ((`RST_MIN_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define RELOAD_MAX_MS 600
`define RELOAD_MAX_CYC ((`RELOAD_MAX_MS * 64'd1000000000) / `CLK_PERIOD_PS)
`define CFG_WORDS 8
`define GAIN_UNITY 16'h4000
`define SAMPLE_W 12
`define FIFO_DEPTH 16
`endif

// [interleave_pkg.sv]
// Types shared by the interleaved converter output block
package interleave_pkg;
  typedef struct packed {
    logic [11:0] a;
    logic [11:0] b;
  } sample_pair_t;
  typedef struct packed {
    logic [15:0] gain;
    logic signed [11:0] offset;
    logic signed [3:0] skew;
  } chan_cfg_t;
  typedef enum logic [1:0] {ST_HOLD, ST_LOAD, ST_RUN} boot_state_t;
endpackage : interleave_pkg

// [sample_fifo.sv]
// Synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module sample_fifo #(
  parameter int WIDTH = 24,
  parameter int DEPTH = 16
) (
  input wire logic ref_clk_i,
  input wire logic srst_i,
  input wire logic [WIDTH-1:0] in_data_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  output logic [WIDTH-1:0] out_data_o,
  output logic out_valid_o,
  input wire logic out_ready_i
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_r;
  logic [AW:0] rd_r;
  wire full = (wr_r[AW] != rd_r[AW]) && (wr_r[AW-1:0] == rd_r[AW-1:0]);
  wire empty = (wr_r == rd_r);
  wire push = in_valid_i && !full;
  wire pop = out_valid_o && out_ready_i;
  assign in_ready_o = !full;
  assign out_valid_o = !empty;
  assign out_data_o = mem[rd_r[AW-1:0]];
  always_ff @(posedge ref_clk_i) begin
    if (push) mem[wr_r[AW-1:0]] <= in_data_i;
  end
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      wr_r <= '0;
      rd_r <= '0;
    end else begin
      if (push) wr_r <= wr_r + 1'b1;
      if (pop) rd_r <= rd_r + 1'b1;
    end
  end
endmodule : sample_fifo
`default_nettype wire

// [chan_correct.sv]
// One channel's gain, offset and timing-skew correction stage
`timescale 1ns/1ps
`default_nettype none
`include "interleave_defines.svh"
module chan_correct (
  input wire logic ref_clk_i,
  input wire logic srst_i,
  input wire logic [11:0] raw_i,
  input wire interleave_pkg::chan_cfg_t cfg_i,
  input wire logic bypass_i,
  output logic [11:0] corr_o
);
  logic signed [11:0] prev_r;
  wire signed [11:0] raw_s = raw_i;
  wire signed [12:0] diff = 13'(raw_s) - 13'(prev_r);
  wire signed [16:0] skew_term = (17'(diff) * 17'(cfg_i.skew)) >>> 4;
  wire signed [29:0] prod = 30'(raw_s) * 30'($signed({1'b0, cfg_i.gain}));
  wire signed [17:0] scaled = 18'(prod >>> 14);
  wire signed [18:0] sum = 19'(scaled) + 19'(cfg_i.offset) + 19'(skew_term);
  wire signed [11:0] sat = (sum > 19'sd2047) ? 12'sh7ff :
                           (sum < -19'sd2048) ? 12'sh800 : sum[11:0];
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      prev_r <= '0;
      corr_o <= '0;
    end else begin
      prev_r <= raw_s;
      corr_o <= bypass_i ? raw_i : sat;
    end
  end
endmodule : chan_correct
`default_nettype wire

// [interleaved_adc_output_control.sv]
// Encode halving, channel correction, output buses and reset/reload control
// What this block does
// RULE1: The encode clock is halved and the two channel clocks are in antiphase.
// RULE2: Each channel's samples get a gain, offset and timing-skew correction.
// RULE3: Samples leave on two 12-bit buses, each at half the conversion rate.
// RULE4: Every output word is twos complement.
// RULE5: A data-ready strobe goes with each bus to time the capture.
// RULE6: Configuration is loaded from storage automatically at power-up.
// RULE7: An active-low reset input forces a complete reload of configuration.
// RULE8: During reset and reload all data and data-ready outputs are held high.
// RULE9: The outside holds reset low for at least 200 ns.
// RULE10: Reload starts on the rising edge of reset, not while it is low.
// RULE11: Reload finishes within 600 ms of reset release.
// RULE12: Resumed data-ready activity marks the end of reset and reload.
// RULE13: An asynchronous capture-sync pulse is held high at least 5 ns; it is sampled every 25 ns, so a pulse under 25 ns can be missed.
// RULE14: While capture-sync is high both data-ready strobes are suppressed.
// RULE15: After capture-sync release both strobes restart on the next channel A strobe.
// RULE16: Unused capture-sync is tied to digital ground.
// RULE17: Each bus carries one channel; its strobe toggles once per word.
`timescale 1ns/1ps
`default_nettype none
`include "interleave_defines.svh"
module interleaved_adc_output_control #(
  parameter int SW = `SAMPLE_W,
  parameter int DEPTH = `FIFO_DEPTH,
  parameter int CFG_N = `CFG_WORDS,
  parameter longint RELOAD_CYC = `RELOAD_MAX_CYC
) (
  input wire logic ref_clk_i,
  input wire logic srst_i,
  input wire logic reset_n_i,
  input wire logic capture_sync_i,
  input wire logic bypass_i,
  output logic conv_clk_a_o,
  output logic conv_clk_b_o,
  input wire logic [SW-1:0] raw_a_i,
  input wire logic [SW-1:0] raw_b_i,
  output logic [3:0] cfg_addr_o,
  input wire logic [15:0] cfg_data_i,
  output logic [SW-1:0] channel_a_data_o,
  output logic [SW-1:0] channel_b_data_o,
  output logic channel_a_data_ready_o,
  output logic channel_b_data_ready_o,
  output logic fifo_in_ready_o
);
  // Pin synchronisers
  logic rst_s1_r, rst_s2_r, rst_s3_r;
  logic sync_s1_r, sync_s2_r;
  logic [SW-1:0] raw_a_s1_r, raw_a_s2_r, raw_b_s1_r, raw_b_s2_r;
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      // Idle level of the pin, so leaving srst shows no false release
      rst_s1_r <= 1'b1;
      rst_s2_r <= 1'b1;
      rst_s3_r <= 1'b1;
      sync_s1_r <= 1'b0;
      sync_s2_r <= 1'b0;
    end else begin
      rst_s1_r <= reset_n_i;
      rst_s2_r <= rst_s1_r;
      rst_s3_r <= rst_s2_r;
      sync_s1_r <= capture_sync_i;
      sync_s2_r <= sync_s1_r;
    end
  end
  // Data pins are sampled without reset; their value matters only in run
  always_ff @(posedge ref_clk_i) begin
    raw_a_s1_r <= raw_a_i;
    raw_a_s2_r <= raw_a_s1_r;
    raw_b_s1_r <= raw_b_i;
    raw_b_s2_r <= raw_b_s1_r;
  end
  wire rst_low = !rst_s2_r;
  wire rst_rise = rst_s2_r && !rst_s3_r;

  // Encode halving; channel B is the complement of A
  logic half_r;
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) half_r <= 1'b0;
    else half_r <= !half_r; // see RULE1
  end
  assign conv_clk_a_o = half_r;
  assign conv_clk_b_o = !half_r; // see RULE1

  // Boot and reload sequencer
  interleave_pkg::boot_state_t st_r, st_nxt;
  logic [3:0] ld_idx_r;
  logic [63:0] ld_cnt_r;
  interleave_pkg::chan_cfg_t cfg_a_r, cfg_b_r;
  wire load_done = (ld_idx_r == 4'(CFG_N - 1));
  always_comb begin
    st_nxt = st_r;
    unique case (st_r)
      interleave_pkg::ST_HOLD: if (rst_rise) st_nxt = interleave_pkg::ST_LOAD; // see RULE10
      interleave_pkg::ST_LOAD: if (rst_low) st_nxt = interleave_pkg::ST_HOLD;
                               else if (load_done) st_nxt = interleave_pkg::ST_RUN;
      interleave_pkg::ST_RUN: if (rst_low) st_nxt = interleave_pkg::ST_HOLD; // see RULE7
      // The unused fourth code recovers by reloading
      default: st_nxt = interleave_pkg::ST_LOAD;
    endcase
  end
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) st_r <= interleave_pkg::ST_LOAD; // see RULE6
    else st_r <= st_nxt;
  end
  // Storage is read one word per cycle; far below the reload ceiling
  always_ff @(posedge ref_clk_i) begin
    if (srst_i || st_r != interleave_pkg::ST_LOAD) begin
      ld_idx_r <= '0;
      ld_cnt_r <= '0;
    end else begin
      ld_idx_r <= ld_idx_r + 4'd1;
      ld_cnt_r <= ld_cnt_r + 64'd1; // see RULE11
    end
  end
  assign cfg_addr_o = ld_idx_r;
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      cfg_a_r <= '{gain: `GAIN_UNITY, offset: 12'sh000, skew: 4'sh0};
      cfg_b_r <= '{gain: `GAIN_UNITY, offset: 12'sh000, skew: 4'sh0};
    end else if (st_r == interleave_pkg::ST_LOAD) begin
      unique case (ld_idx_r)
        4'd0: cfg_a_r.gain <= cfg_data_i; // see RULE6
        4'd1: cfg_a_r.offset <= cfg_data_i[11:0];
        4'd2: cfg_a_r.skew <= cfg_data_i[3:0];
        4'd3: cfg_b_r.gain <= cfg_data_i;
        4'd4: cfg_b_r.offset <= cfg_data_i[11:0];
        4'd5: cfg_b_r.skew <= cfg_data_i[3:0];
        default: ;
      endcase
    end
  end
  wire running = (st_r == interleave_pkg::ST_RUN);

  // Correction per channel
  logic [SW-1:0] corr_a, corr_b;
  chan_correct u_corr_a (
    .ref_clk_i(ref_clk_i),
    .srst_i(srst_i),
    .raw_i(raw_a_s2_r),
    .cfg_i(cfg_a_r),
    .bypass_i(bypass_i),
    .corr_o(corr_a) // see RULE2
  );
  chan_correct u_corr_b (
    .ref_clk_i(ref_clk_i),
    .srst_i(srst_i),
    .raw_i(raw_b_s2_r),
    .cfg_i(cfg_b_r),
    .bypass_i(bypass_i),
    .corr_o(corr_b) // see RULE2
  );

  // Sample pairs enter the FIFO once per half-rate period
  interleave_pkg::sample_pair_t in_pair, out_pair;
  logic out_valid, out_ready;
  assign in_pair = '{a: corr_a, b: corr_b}; // see RULE4
  wire in_valid = running && half_r;
  sample_fifo #(.WIDTH(2 * SW), .DEPTH(DEPTH)) u_fifo (
    .ref_clk_i(ref_clk_i),
    .srst_i(srst_i || !running),
    .in_data_i(in_pair),
    .in_valid_i(in_valid),
    .in_ready_o(fifo_in_ready_o),
    .out_data_o(out_pair),
    .out_valid_o(out_valid),
    .out_ready_i(out_ready)
  );

  // Output side: one word per half-rate period, strobe toggles per word
  logic phase_r, gate_r, strobe_r;
  logic [SW-1:0] da_r, db_r;
  assign out_ready = running && phase_r;
  wire emit = out_valid && out_ready;
  always_ff @(posedge ref_clk_i) begin
    if (srst_i || !running) phase_r <= 1'b0;
    else phase_r <= !phase_r;
  end
  // Gate opens only on a new word, so both strobes restart together on A
  always_ff @(posedge ref_clk_i) begin
    if (srst_i || !running || sync_s2_r) gate_r <= 1'b0; // see RULE14
    else if (emit) gate_r <= 1'b1; // see RULE15
  end
  always_ff @(posedge ref_clk_i) begin
    if (srst_i || !running) begin
      strobe_r <= 1'b0;
      da_r <= {SW{1'b1}};
      db_r <= {SW{1'b1}};
    end else if (emit) begin
      strobe_r <= 1'b1; // see RULE17
      da_r <= out_pair.a; // see RULE3
      db_r <= out_pair.b;
    end else begin
      strobe_r <= 1'b0; // see RULE17
    end
  end
  wire hold_high = !running;
  wire strobe_on = gate_r && !sync_s2_r;
  assign channel_a_data_o = hold_high ? {SW{1'b1}} : da_r; // see RULE8
  assign channel_b_data_o = hold_high ? {SW{1'b1}} : db_r; // see RULE8
  assign channel_a_data_ready_o = hold_high ? 1'b1 : (strobe_on && strobe_r); // see RULE5
  assign channel_b_data_ready_o = hold_high ? 1'b1 : (strobe_on && strobe_r); // see RULE12

  // Assertions
  property p_antiphase;
    @(posedge ref_clk_i) disable iff (srst_i)
      conv_clk_a_o != conv_clk_b_o;
  endproperty
  a_antiphase: assert property (p_antiphase) // see RULE1
    else $error("channel clocks not antiphase");
  property p_halving;
    @(posedge ref_clk_i) disable iff (srst_i)
      conv_clk_a_o |=> !conv_clk_a_o;
  endproperty
  a_halving: assert property (p_halving) // see RULE1
    else $error("encode clock not halved");
  property p_halving_b;
    @(posedge ref_clk_i) disable iff (srst_i)
      !conv_clk_b_o |=> conv_clk_b_o;
  endproperty
  a_halving_b: assert property (p_halving_b) // see RULE1
    else $error("channel b clock not halved");

  property p_power_up_load;
    @(posedge ref_clk_i) disable iff (srst_i)
      $fell(srst_i) |-> st_r == interleave_pkg::ST_LOAD;
  endproperty
  a_power_up_load: assert property (p_power_up_load) // see RULE6
    else $error("no load after power-up");
  sequence s_loading;
    st_r == interleave_pkg::ST_LOAD && !rst_low;
  endsequence
  property p_load_step;
    @(posedge ref_clk_i) disable iff (srst_i)
      s_loading ##0 !load_done |=> ld_idx_r == $past(ld_idx_r) + 4'd1;
  endproperty
  a_load_step: assert property (p_load_step) // see RULE6
    else $error("configuration word skipped");
  property p_addr_range;
    @(posedge ref_clk_i) disable iff (srst_i)
      s_loading |-> cfg_addr_o < 4'(CFG_N);
  endproperty
  a_addr_range: assert property (p_addr_range) // see RULE6
    else $error("configuration address out of range");
  sequence s_load_end;
    s_loading ##0 load_done;
  endsequence
  property p_run_after_load;
    @(posedge ref_clk_i) disable iff (srst_i)
      s_load_end |=> running && !channel_a_data_ready_o;
  endproperty
  a_run_after_load: assert property (p_run_after_load) // see RULE12
    else $error("strobe activity not resumed after load");

  sequence s_release;
    st_r == interleave_pkg::ST_HOLD ##1 rst_rise;
  endsequence
  property p_reload_bound;
    @(posedge ref_clk_i) disable iff (srst_i)
      s_release |=> (st_r == interleave_pkg::ST_LOAD) ##[1:20] (running || rst_low);
  endproperty
  a_reload_bound: assert property (p_reload_bound) // see RULE11
    else $error("reload too long");
  property p_reload_ceiling;
    @(posedge ref_clk_i) disable iff (srst_i)
      st_r == interleave_pkg::ST_LOAD |-> ld_cnt_r < 64'(RELOAD_CYC);
  endproperty
  a_reload_ceiling: assert property (p_reload_ceiling) // see RULE11
    else $error("reload past its ceiling");
  property p_release_waits;
    @(posedge ref_clk_i) disable iff (srst_i)
      st_r == interleave_pkg::ST_HOLD && !rst_rise |=> st_r == interleave_pkg::ST_HOLD;
  endproperty
  a_release_waits: assert property (p_release_waits) // see RULE10
    else $error("reload started before release");
  property p_no_load_low;
    @(posedge ref_clk_i) disable iff (srst_i)
      rst_low |=> st_r == interleave_pkg::ST_HOLD;
  endproperty
  a_no_load_low: assert property (p_no_load_low) // see RULE10
    else $error("reload while reset low");

  property p_hold_high;
    @(posedge ref_clk_i) disable iff (srst_i)
      !running |-> (&channel_a_data_o) && (&channel_b_data_o) && channel_a_data_ready_o;
  endproperty
  a_hold_high: assert property (p_hold_high) // see RULE8
    else $error("outputs not high in reset");
  sequence s_pin_held;
    rst_low [*2];
  endsequence
  property p_pin_hold;
    @(posedge ref_clk_i) disable iff (srst_i)
      s_pin_held |-> channel_b_data_ready_o && (&channel_b_data_o);
  endproperty
  a_pin_hold: assert property (p_pin_hold) // see RULE7
    else $error("pin reset did not hold outputs high");

  property p_sync_quiet;
    @(posedge ref_clk_i) disable iff (srst_i)
      running && sync_s2_r |-> !channel_a_data_ready_o && !channel_b_data_ready_o;
  endproperty
  a_sync_quiet: assert property (p_sync_quiet) // see RULE14
    else $error("strobe during capture sync");
  property p_together;
    @(posedge ref_clk_i) disable iff (srst_i)
      channel_a_data_ready_o == channel_b_data_ready_o;
  endproperty
  a_together: assert property (p_together) // see RULE15
    else $error("strobes not together");
  property p_restart_on_word;
    @(posedge ref_clk_i) disable iff (srst_i)
      running && !rst_low && !gate_r && !emit |=> !channel_a_data_ready_o;
  endproperty
  a_restart_on_word: assert property (p_restart_on_word) // see RULE15
    else $error("strobe restarted without a new word");

  property p_strobe_once;
    @(posedge ref_clk_i) disable iff (srst_i)
      running && !rst_low && $rose(channel_a_data_ready_o) |=> !channel_a_data_ready_o;
  endproperty
  a_strobe_once: assert property (p_strobe_once) // see RULE17
    else $error("strobe longer than one cycle");
  property p_strobe_gap;
    @(posedge ref_clk_i) disable iff (srst_i)
      strobe_r |=> !strobe_r;
  endproperty
  a_strobe_gap: assert property (p_strobe_gap) // see RULE17
    else $error("strobe does not toggle per word");
  property p_emit_spacing;
    @(posedge ref_clk_i) disable iff (srst_i)
      emit |=> !emit;
  endproperty
  a_emit_spacing: assert property (p_emit_spacing) // see RULE3
    else $error("words leave faster than half rate");
  property p_no_overflow;
    @(posedge ref_clk_i) disable iff (srst_i)
      in_valid |-> fifo_in_ready_o;
  endproperty
  a_no_overflow: assert property (p_no_overflow) // see RULE3
    else $error("sample pair lost at full buffer");
  property p_data_stands;
    @(posedge ref_clk_i) disable iff (srst_i)
      running && !emit |=> $stable(da_r) && $stable(db_r);
  endproperty
  a_data_stands: assert property (p_data_stands) // see RULE5
    else $error("output word changed without a strobe");
endmodule : interleaved_adc_output_control
`default_nettype wire

// [capture_model.sv]
// Far-side model: configuration storage and capture of both output buses
`timescale 1ns/1ps
`default_nettype none
module capture_model (
  input wire logic ref_clk_i,
  input wire logic clear_i,
  input wire logic [3:0] cfg_addr_i,
  output logic [15:0] cfg_data_o,
  input wire logic [11:0] a_data_i,
  input wire logic [11:0] b_data_i,
  input wire logic a_ready_i,
  output logic [11:0] cap_a_o,
  output logic [11:0] cap_b_o,
  output logic [15:0] pulses_o
);
  logic ready_q;
  // Unity gain and no skew keep the expected words exact
  always_comb begin
    case (cfg_addr_i)
      4'h0, 4'h3: cfg_data_o = 16'h4000;
      4'h1: cfg_data_o = 16'h0005;
      4'h4: cfg_data_o = 16'h0ffd;
      default: cfg_data_o = 16'h0000;
    endcase
  end
  // Strobe held high in reload is no edge, so it captures nothing
  always_ff @(posedge ref_clk_i) begin
    ready_q <= a_ready_i;
    if (clear_i) begin
      pulses_o <= 16'h0000;
    end else if (a_ready_i && !ready_q) begin
      cap_a_o <= a_data_i;
      cap_b_o <= b_data_i;
      pulses_o <= pulses_o + 16'h0001;
    end
  end
endmodule : capture_model
`default_nettype wire

// [test_interleaved_adc_output_control.sv]
// Self-checking bench for the interleaved converter output block
`timescale 1ns/1ps
`default_nettype none
module test_interleaved_adc_output_control;
  logic ref_clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic reset_n_i = 1'b1;
  logic capture_sync_i = 1'b0;
  logic bypass_i = 1'b1;
  logic [11:0] raw_a = 12'h800;
  logic [11:0] raw_b = 12'h7ff;
  logic clk_a, clk_b, dr_a, dr_b, fifo_rdy;
  logic [3:0] cfg_addr;
  logic [15:0] cfg_data, pulses;
  logic [11:0] data_a, data_b, cap_a, cap_b;
  int num_errors = 0;
  int checked = 0;
  always #12.5 ref_clk_i = ~ref_clk_i;
  interleaved_adc_output_control i_interleaved_adc_output_control (
    .ref_clk_i(ref_clk_i), .srst_i(srst_i), .reset_n_i(reset_n_i),
    .capture_sync_i(capture_sync_i), .bypass_i(bypass_i),
    .conv_clk_a_o(clk_a), .conv_clk_b_o(clk_b), .raw_a_i(raw_a), .raw_b_i(raw_b),
    .cfg_addr_o(cfg_addr), .cfg_data_i(cfg_data), .channel_a_data_o(data_a),
    .channel_b_data_o(data_b), .channel_a_data_ready_o(dr_a),
    .channel_b_data_ready_o(dr_b), .fifo_in_ready_o(fifo_rdy));
  capture_model i_capture_model (
    .ref_clk_i(ref_clk_i), .clear_i(srst_i), .cfg_addr_i(cfg_addr),
    .cfg_data_o(cfg_data), .a_data_i(data_a), .b_data_i(data_b),
    .a_ready_i(dr_a), .cap_a_o(cap_a), .cap_b_o(cap_b), .pulses_o(pulses));
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // Outputs stay high through reload, all eight words are read, strobes then resume
  task automatic boot();
    logic [15:0] seen;
    logic ones;
    int n;
    seen = 16'h0000;
    ones = 1'b1;
    n = 0;
    while (dr_a !== 1'b0 && n < 60) begin
      @(negedge ref_clk_i);
      if (dr_a === 1'b1) begin
        seen[cfg_addr] = 1'b1;
        ones = ones & (&{data_a, data_b, dr_b});
      end
      n++;
    end
    chk("config words read", 16'h00ff, seen);
    chk("outputs high in reload", 16'h0001, {15'h0000, ones});
    chk("strobe resumed", 16'h0000, {15'h0000, dr_a});
  endtask : boot
  // Counts strobe pulses; the two strobes must agree and never stay high
  task automatic watch(input int cyc, input logic [15:0] exp);
    logic prev;
    int n;
    prev = 1'b0;
    n = 0;
    repeat (cyc) begin
      @(negedge ref_clk_i);
      chk("strobe pair", {15'h0000, dr_a}, {15'h0000, dr_b});
      chk("strobe width", 16'h0000, {15'h0000, prev & dr_a});
      prev = dr_a;
      n += (dr_a === 1'b1);
    end
    chk("strobe count", exp, n[15:0]);
  endtask : watch
  task automatic t_clock();
    logic last;
    @(negedge ref_clk_i);
    last = clk_a;
    repeat (4) begin
      @(negedge ref_clk_i);
      chk("channel b clock", {15'h0000, ~clk_a}, {15'h0000, clk_b});
      chk("channel a clock", {15'h0000, ~last}, {15'h0000, clk_a});
      last = clk_a;
    end
  endtask : t_clock
  // Extreme codes pass untouched in bypass, each on its own bus
  task automatic t_bypass();
    repeat (30) @(posedge ref_clk_i);
    watch(20, 16'd10);
    chk("bus a word", 16'h0800, {4'h0, cap_a});
    chk("bus b word", 16'h07ff, {4'h0, cap_b});
    chk("fifo ready", 16'h0001, {15'h0000, fifo_rdy});
  endtask : t_bypass
  task automatic t_correct();
    @(posedge ref_clk_i);
    bypass_i <= 1'b0;
    raw_a <= 12'h100;
    raw_b <= 12'h100;
    repeat (30) @(posedge ref_clk_i);
    chk("corrected a", 16'h0105, {4'h0, cap_a});
    chk("corrected b", 16'h00fd, {4'h0, cap_b});
  endtask : t_correct
  // Held low ten cycles; no strobe may run before the release
  task automatic t_pin_reset();
    @(posedge ref_clk_i);
    reset_n_i <= 1'b0;
    repeat (10) @(posedge ref_clk_i);
    chk("held in reset", 16'h1fff, {3'h0, dr_a, data_a});
    reset_n_i <= 1'b1;
    @(posedge ref_clk_i);
    boot();
  endtask : t_pin_reset
  task automatic t_sync();
    int n;
    logic [15:0] p0;
    @(posedge ref_clk_i);
    capture_sync_i <= 1'b1;
    repeat (4) @(posedge ref_clk_i);
    p0 = pulses;
    watch(20, 16'd0);
    chk("captures during sync", p0, pulses);
    @(posedge ref_clk_i);
    capture_sync_i <= 1'b0;
    n = 0;
    while (dr_a !== 1'b1 && n < 20) begin
      @(negedge ref_clk_i);
      n++;
    end
    chk("restart together", 16'h0003, {14'h0000, dr_a, dr_b});
    watch(20, 16'd10);
  endtask : t_sync
  task automatic report_and_stop();
    $display("checked %0d num_errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : report_and_stop
  initial begin
    repeat (6) @(posedge ref_clk_i);
    srst_i <= 1'b0;
    boot();
    t_clock();
    t_bypass();
    t_correct();
    t_pin_reset();
    t_sync();
    report_and_stop();
  end
  // Whole run is under two hundred cycles, so this only catches a hang
  initial begin
    repeat (5000) @(posedge ref_clk_i);
    num_errors++;
    report_and_stop();
  end
endmodule : test_interleaved_adc_output_control
`default_nettype wire
